// ### hw/periodic_timer_compare_unit.sv
/*
 * Periodic timer compare unit: 10-bit count-up counter with two
 * comparators, compare-match output, PWM/single-pulse output, capture
 * and timer/counter modes, reached over a plain byte register port.
 * Assumes a single clock, pins asynchronous to it, and tick strobes
 * for the high and sub clocks supplied as pins.
 */
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
//
// Contract
// - three-bit field picks counter clock source
// - pause holds count, resume from held
// - reserved clock code stops counting
// - counter-on rise clears; low retains count
// - counter-on rise restores initial output level
// - two-bit field decodes four operating modes
// - compare A match: none, low, high, toggle
// - PWM mode: inactive, active, PWM, pulse
// - capture edge rising, falling, both, off
// - output control sets initial/active level
// - polarity inverts outputs, ignored in timer
// - capture source: pin 0 input or clock pin
// - clear select: A match, else P/overflow
// - clear select ignored in PWM, capture
// - counter readable as low/high bytes
// - compare A and P read/write bytes
// - compare mode, clear low: both flags
// - clear high: only compare A flag
// - compare A zero: overflow, no flag
// - only compare A match moves pin
`timescale 1ns/10ps
`default_nettype none
`include "periodic_timer_defs.svh"

module periodic_timer_compare_unit (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic [7:0]      regRdData,
    input  wire logic       highClkTick,
    input  wire logic       subClkTick,
    input  wire logic       timerClockPin,
    input  wire logic       timerPin0In,
    input  wire logic       timerPin1In,
    output logic            timerOutputPin0,
    output logic            timerOutputPin1,
    output logic            timerOutputEnable,
    output logic            compareAFlag,
    output logic            comparePFlag
);
    import periodic_timer_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0] controlReg_q;
    logic [7:0] modeReg_q;
    count_t     count_q;
    count_t     compareA_q;
    count_t     compareP_q;
    logic       onPrev_q;
    logic [2:0] ckPinSync_q;
    logic [2:0] pin0Sync_q;
    logic [2:0] pin1Sync_q;
    logic [1:0] sysDiv_q;
    logic [3:0] highDiv16_q;
    logic [5:0] highDiv64_q;
    logic [1:0] tickSync_q;
    logic [1:0] subSync_q;
    logic       highPrev_q;
    logic       subPrev_q;
    logic       outLevel_q;
    logic       flagA_q;
    logic       flagP_q;
    logic       tick;
    logic       onRise;
    logic       matchA;
    logic       matchP;
    logic       clearCount;
    logic       flagASet;
    logic       flagPSet;
    logic       capEdge;
    logic       capTrigSig;
    logic       capTrigPrev;
    logic       pwmLevel;
    logic       pinLevel;
    logic       highTick;
    logic       subTick;
    opMode_t    mode;
    clkSel_t    ckSel;
    logic [1:0] func;
    logic       counterOn;
    logic       wrCtrlClearsOn;

    assign mode      = opMode_t'(modeReg_q[`MODE_HI:`MODE_LO]);
    assign ckSel     = clkSel_t'(controlReg_q[`CKSEL_HI:`CKSEL_LO]);
    assign func      = modeReg_q[`FUNC_HI:`FUNC_LO];
    assign counterOn = controlReg_q[`BIT_ON];
    assign onRise    = counterOn & ~onPrev_q;

    // ------------------------------------------------------------------
    // Pin synchronisers and edge history
    // ------------------------------------------------------------------
    // Two stages, third stage is edge history only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ckPinSync_q <= 3'h0;
            pin0Sync_q  <= 3'h0;
            pin1Sync_q  <= 3'h0;
            tickSync_q  <= 2'h0;
            subSync_q   <= 2'h0;
            highPrev_q  <= 1'b0;
            subPrev_q   <= 1'b0;
        end else begin
            ckPinSync_q <= {ckPinSync_q[1:0], timerClockPin};
            pin0Sync_q  <= {pin0Sync_q[1:0], timerPin0In};
            pin1Sync_q  <= {pin1Sync_q[1:0], timerPin1In};
            tickSync_q  <= {tickSync_q[0], highClkTick};
            subSync_q   <= {subSync_q[0], subClkTick};
            highPrev_q  <= tickSync_q[1];
            subPrev_q   <= subSync_q[1];
        end
    end

    assign highTick = tickSync_q[1] & ~highPrev_q;
    assign subTick  = subSync_q[1] & ~subPrev_q;

    // ------------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------------
    // Free-running dividers for internal sources
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sysDiv_q    <= 2'h0;
            highDiv16_q <= 4'h0;
            highDiv64_q <= 6'h0;
        end else begin
            sysDiv_q <= sysDiv_q + 2'h1;
            if (highTick) begin
                highDiv16_q <= highDiv16_q + 4'h1;
                highDiv64_q <= highDiv64_q + 6'h1;
            end
        end
    end

    // Clock source select
    always_comb begin
        case (ckSel)
            CK_SYS_DIV4: tick = (sysDiv_q == `SYS_DIV4);
            CK_SYS:      tick = 1'b1;
            CK_HIGH_D16: tick = highTick & (highDiv16_q == `HIGH_DIV16);
            CK_HIGH_D64: tick = highTick & (highDiv64_q == `HIGH_DIV64);
            CK_SUB:      tick = subTick;
            CK_RESERVED: tick = 1'b0;
            CK_PIN_RISE: tick = ckPinSync_q[1] & ~ckPinSync_q[2];
            CK_PIN_FALL: tick = ~ckPinSync_q[1] & ckPinSync_q[2];
            default:     tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Comparators and clear logic
    // ------------------------------------------------------------------
    // Matches judged on the counter at a tick
    always_comb begin
        matchA     = tick & (compareA_q != 10'h0) & (count_q == compareA_q);
        matchP     = tick & (compareP_q != 10'h0) & (count_q == compareP_q);
        clearCount = 1'b0;
        flagASet   = 1'b0;
        flagPSet   = 1'b0;
        case (mode)
            MODE_COMPARE, MODE_TIMER: begin
                flagASet = matchA;
                if (modeReg_q[`BIT_CLRSEL]) begin
                    clearCount = matchA;
                end else begin
                    flagPSet   = matchP;
                    clearCount = matchP;
                end
                // P flag suppressed when clear high
            end
            MODE_PWM: begin
                flagASet   = matchA;
                flagPSet   = matchP;
                clearCount = (func == 2'h3) ? 1'b0 : matchP;
            end
            MODE_CAPTURE: begin
                flagPSet   = matchP;
                clearCount = matchP;
            end
            default: clearCount = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Count, pause and restart
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q  <= 10'h0;
            onPrev_q <= 1'b0;
        end else begin
            onPrev_q <= counterOn;
            if (onRise) begin
                count_q <= 10'h0;
            end else if (counterOn && !controlReg_q[`BIT_PAUSE] && tick) begin
                if (clearCount) begin
                    count_q <= 10'h0;
                end else begin
                    count_q <= count_q + 10'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Capture trigger
    // ------------------------------------------------------------------
    // capture source select
    assign capTrigSig  = modeReg_q[`BIT_CAPSRC] ? ckPinSync_q[1] : pin0Sync_q[1];
    assign capTrigPrev = modeReg_q[`BIT_CAPSRC] ? ckPinSync_q[2] : pin0Sync_q[2];

    always_comb begin
        case (func)
            2'h0:    capEdge = capTrigSig & ~capTrigPrev;
            2'h1:    capEdge = ~capTrigSig & capTrigPrev;
            2'h2:    capEdge = capTrigSig ^ capTrigPrev;
            default: capEdge = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    assign wrCtrlClearsOn = (mode == MODE_PWM) && (func == 2'h3) && matchA && counterOn;

    // Control registers; single pulse ends by clearing counter-on
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            controlReg_q <= `RST_CONTROL;
            modeReg_q    <= `RST_MODE_OUTPUT;
        end else begin
            if (regWrite && regAddr == `OFS_COUNTER_CONTROL) begin
                controlReg_q <= {regWrData[7:3], 3'h0};
            end else if (wrCtrlClearsOn) begin
                controlReg_q[`BIT_ON] <= 1'b0;
            end
            if (regWrite && regAddr == `OFS_MODE_OUTPUT_CTL) begin
                modeReg_q <= regWrData;
            end
        end
    end

    // Compare values; capture loads compare A
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            compareA_q <= 10'h0;
            compareP_q <= 10'h0;
        end else begin
            if (regWrite && regAddr == `OFS_COMPARE_A_LOW) begin
                compareA_q[7:0] <= regWrData;
            end else if (regWrite && regAddr == `OFS_COMPARE_A_HIGH) begin
                compareA_q[9:8] <= regWrData[1:0];
            end else if (mode == MODE_CAPTURE && counterOn && capEdge) begin
                compareA_q <= count_q;
            end
            if (regWrite && regAddr == `OFS_COMPARE_P_LOW) begin
                compareP_q[7:0] <= regWrData;
            end else if (regWrite && regAddr == `OFS_COMPARE_P_HIGH) begin
                compareP_q[9:8] <= regWrData[1:0];
            end
        end
    end

    // Sticky flags: set wins over write-one clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flagA_q <= 1'b0;
            flagP_q <= 1'b0;
        end else begin
            if (flagASet || (mode == MODE_CAPTURE && counterOn && capEdge)) begin
                flagA_q <= 1'b1;
            end else if (regWrite && regAddr == `OFS_FLAG_STATUS && regWrData[0]) begin
                flagA_q <= 1'b0;
            end
            if (flagPSet) begin
                flagP_q <= 1'b1;
            end else if (regWrite && regAddr == `OFS_FLAG_STATUS && regWrData[1]) begin
                flagP_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output level
    // ------------------------------------------------------------------
    // Compare-match output state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            outLevel_q <= 1'b0;
        end else if (onRise) begin
            outLevel_q <= modeReg_q[`BIT_OUTCTL];
        end else if (mode == MODE_COMPARE && flagASet && counterOn
                     && !controlReg_q[`BIT_PAUSE]) begin
            // action on compare A; P never moves pin
            case (func)
                2'h1:    outLevel_q <= 1'b0;
                2'h2:    outLevel_q <= 1'b1;
                2'h3:    outLevel_q <= ~outLevel_q;
                default: outLevel_q <= outLevel_q;
            endcase
        end
    end

    // PWM and single-pulse waveform
    always_comb begin
        case (func)
            2'h0:    pwmLevel = 1'b0;
            2'h1:    pwmLevel = 1'b1;
            2'h2:    pwmLevel = counterOn & (count_q < compareA_q);
            default: pwmLevel = counterOn;
        endcase
        pwmLevel = modeReg_q[`BIT_OUTCTL] ? pwmLevel : ~pwmLevel;
        pinLevel = (mode == MODE_PWM) ? pwmLevel : outLevel_q;
        pinLevel = pinLevel ^ modeReg_q[`BIT_POLARITY];
    end

    // Registered pin drive; timer and capture modes release the pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timerOutputPin0   <= 1'b0;
            timerOutputPin1   <= 1'b0;
            timerOutputEnable <= 1'b0;
        end else begin
            timerOutputPin0   <= pinLevel;
            timerOutputPin1   <= pinLevel;
            timerOutputEnable <= (mode == MODE_COMPARE) || (mode == MODE_PWM);
        end
    end

    // ------------------------------------------------------------------
    // Read port and flag outputs
    // ------------------------------------------------------------------
    // Read data one cycle after strobe; unmapped reads zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            regRdData    <= 8'h00;
            compareAFlag <= 1'b0;
            comparePFlag <= 1'b0;
        end else begin
            compareAFlag <= flagA_q;
            comparePFlag <= flagP_q;
            regRdData    <= 8'h00;
            if (regRead) begin
                case (regAddr)
                    `OFS_COUNTER_CONTROL: regRdData <= controlReg_q;
                    `OFS_MODE_OUTPUT_CTL: regRdData <= modeReg_q;
                    `OFS_COUNT_LOW:       regRdData <= count_q[7:0];
                    `OFS_COUNT_HIGH:      regRdData <= {6'h0, count_q[9:8]};
                    `OFS_COMPARE_A_LOW:   regRdData <= compareA_q[7:0];
                    `OFS_COMPARE_A_HIGH:  regRdData <= {6'h0, compareA_q[9:8]};
                    `OFS_COMPARE_P_LOW:   regRdData <= compareP_q[7:0];
                    `OFS_COMPARE_P_HIGH:  regRdData <= {6'h0, compareP_q[9:8]};
                    `OFS_FLAG_STATUS:     regRdData <= {6'h0, flagP_q, flagA_q};
                    default:              regRdData <= 8'h00;
                endcase
            end
        end
    end

endmodule : periodic_timer_compare_unit
`default_nettype wire

// ### hw/periodic_timer_defs.svh
/*
 * Register offsets, field positions, reset values and prescaler terminal counts
 * for the periodic timer compare unit.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef PERIODIC_TIMER_DEFS_SVH
`define PERIODIC_TIMER_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte index on the plain register port)
// ----------------------------------------------------------------------
`define OFS_COUNTER_CONTROL 4'h0
`define OFS_MODE_OUTPUT_CTL 4'h1
`define OFS_COUNT_LOW       4'h2
`define OFS_COUNT_HIGH      4'h3
`define OFS_COMPARE_A_LOW   4'h4
`define OFS_COMPARE_A_HIGH  4'h5
`define OFS_COMPARE_P_LOW   4'h6
`define OFS_COMPARE_P_HIGH  4'h7
`define OFS_FLAG_STATUS     4'h8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_PAUSE           7
`define BIT_ON              3
`define CKSEL_HI            6
`define CKSEL_LO            4
`define MODE_HI             7
`define MODE_LO             6
`define FUNC_HI             5
`define FUNC_LO             4
`define BIT_OUTCTL          3
`define BIT_POLARITY        2
`define BIT_CAPSRC          1
`define BIT_CLRSEL          0

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define RST_CONTROL         8'h00
`define RST_MODE_OUTPUT     8'h00
`define HIGH_DIV16          4'hf
`define HIGH_DIV64          6'h3f
`define SYS_DIV4            2'h3

`endif

// ### hw/periodic_timer_pkg.sv
/*
 * Types for the periodic timer compare unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package periodic_timer_pkg;

    // Operating mode field encoding
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM     = 2'h2,
        MODE_TIMER   = 2'h3
    } opMode_t;

    // Counter clock source field encoding
    typedef enum logic [2:0] {
        CK_SYS_DIV4  = 3'h0,
        CK_SYS       = 3'h1,
        CK_HIGH_D16  = 3'h2,
        CK_HIGH_D64  = 3'h3,
        CK_SUB       = 3'h4,
        CK_RESERVED  = 3'h5,
        CK_PIN_RISE  = 3'h6,
        CK_PIN_FALL  = 3'h7
    } clkSel_t;

    typedef logic [9:0] count_t;

endpackage : periodic_timer_pkg

// ### tb/periodic_timer_compare_unit_asserts.sv
/* Port checker for the periodic timer compare unit.
   Assumes a bind onto the top module, one clock, async low reset. */
`timescale 1ns/10ps
`default_nettype none
module periodic_timer_compare_unit_asserts (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic       timerOutputPin0,
    input wire logic       timerOutputPin1,
    input wire logic       timerOutputEnable,
    input wire logic       compareAFlag,
    input wire logic       comparePFlag
);
    logic [1:0] modeQ;
    logic       clrSelQ;
    wire logic  pBlock = (modeQ == 2'h0) && clrSelQ;
    wire logic  clrA = regWrite && (regAddr == 4'h8) && regWrData[0];
    wire logic  clrP = regWrite && (regAddr == 4'h8) && regWrData[1];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Shadow of mode and clear-select fields
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            modeQ   <= 2'h0;
            clrSelQ <= 1'b0;
        end else if (regWrite && regAddr == 4'h1) begin
            modeQ   <= regWrData[7:6];
            clrSelQ <= regWrData[0];
        end
    end
    // Read strobe at one address
    sequence rdAt(logic [3:0] a);
        regRead && regAddr == a;
    endsequence
    a_idle_rd_zero: assert property (!regRead |=> regRdData == 8'h00)
        else $error("idle read data set");
    a_cnt_high_zero: assert property (rdAt(4'h3) |=> regRdData[7:2] == 6'h00)
        else $error("count high spare bits");
    a_cmp_high_zero: assert property (rdAt(4'h5) or rdAt(4'h7) |=> regRdData[7:2] == 6'h00)
        else $error("compare high spare bits");
    a_pins_agree: assert property (timerOutputPin0 == timerOutputPin1)
        else $error("output pins differ");
    a_oe_by_mode: assert property ($stable(modeQ) [*3] |->
        timerOutputEnable == (modeQ == 2'h0 || modeQ == 2'h2))
        else $error("enable wrong for mode");
    a_no_p_flag: assert property ($rose(comparePFlag) |-> !($past(pBlock) && $past(pBlock, 2)))
        else $error("P flag with clear on A");
    a_a_flag_held: assert property ($fell(compareAFlag) |-> $past(clrA) || $past(clrA, 2))
        else $error("A flag lost");
    a_p_flag_held: assert property ($fell(comparePFlag) |-> $past(clrP) || $past(clrP, 2))
        else $error("P flag lost");
endmodule : periodic_timer_compare_unit_asserts
`default_nettype wire

// ### tb/timer_pin_model.sv
/* Pin-side partner: tick sources and shared timer pins.
   Assumes the bench drives the outside pin level at clock edges. */
`timescale 1ns/10ps
`default_nettype none
module timer_pin_model (
    input  wire logic clk_sys,
    input  wire logic extPin,
    input  wire logic outPin0,
    input  wire logic outPin1,
    input  wire logic outEn,
    output logic      highClkTick,
    output logic      subClkTick,
    output logic      timerClockPin,
    output logic      timerPin0In,
    output logic      timerPin1In
);
    logic [3:0] divQ = 4'h0;
    // Free-running dividers for the tick pins
    always @(posedge clk_sys) divQ <= divQ + 4'h1;
    assign highClkTick   = divQ[1];
    assign subClkTick    = divQ[2];
    assign timerClockPin = divQ[3];
    // Driver wins while enabled, else the outside source
    assign timerPin0In = outEn ? outPin0 : extPin;
    assign timerPin1In = outEn ? outPin1 : extPin;
endmodule : timer_pin_model
`default_nettype wire

// ### tb/periodic_timer_compare_unit_tb.sv
/* Self-checking bench for the periodic timer compare unit.
   Assumes package, design, checker and pin model compile first. */
`timescale 1ns/10ps
`default_nettype none
module periodic_timer_compare_unit_tb;
    logic        clk_sys, reset_n, regWrite, regRead, extPin;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData, d, e;
    logic [8:0]  expQ[$], note;
    logic [31:0] rng = 32'h0000a3b2, r;
    logic        rdPend = 1'b0;
    int          mismatches, n_checks, n;
    int          act[4] = '{0, 200, 97, 12};
    logic [7:0]  rate[8] = '{8'h20, 8'h80, 8'h02, 8'h00, 8'h10, 8'h00, 8'h08, 8'h08};
    wire logic [7:0] regRdData;
    wire logic   highClkTick, subClkTick, timerClockPin, timerPin0In, timerPin1In;
    wire logic   pin0, pin1, outEn, flagA, flagP;
    periodic_timer_compare_unit u_dut (
        .clk_sys, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .highClkTick, .subClkTick, .timerClockPin, .timerPin0In, .timerPin1In,
        .timerOutputPin0(pin0), .timerOutputPin1(pin1), .timerOutputEnable(outEn),
        .compareAFlag(flagA), .comparePFlag(flagP));
    timer_pin_model u_pins (
        .clk_sys, .extPin, .outPin0(pin0), .outPin1(pin1), .outEn,
        .highClkTick, .subClkTick, .timerClockPin, .timerPin0In, .timerPin1In);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function logic [31:0] xorshift();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xorshift
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWrite  <= 1'b0;
    endtask : wr
    task rdn(input logic [8:0] nt, input logic [3:0] a, output logic [7:0] v);
        expQ.push_back(nt);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        v = regRdData;
    endtask : rdn
    task rd(input logic [3:0] a, output logic [7:0] v);
        rdn(9'h000, a, v);
    endtask : rd
    task rde(input logic [3:0] a, input logic [7:0] v);
        rdn({1'b1, v}, a, d);
    endtask : rde
    task cmp(input logic [9:0] a, input logic [9:0] p);
        wr(4'h4, a[7:0]);
        wr(4'h5, {6'h00, a[9:8]});
        wr(4'h6, p[7:0]);
        wr(4'h7, {6'h00, p[9:8]});
    endtask : cmp
    task start(input logic [7:0] m, input logic [7:0] c);
        wr(4'h0, 8'h00);
        wr(4'h8, 8'h03);
        wr(4'h1, m);
        wr(4'h0, c);
    endtask : start
    // ----------------------------------------------------------------
    // Clock, read monitor, watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) rdPend <= regRead;
    // Pair each read result with the oldest note
    always @(negedge clk_sys) begin
        if (rdPend) begin
            note = expQ.pop_front();
            if (note[8]) check(regRdData, note[7:0]);
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 4'h0;
        regWrData = 8'h00;
        extPin = 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int a = 0; a < 10; a++) rde(a[3:0], 8'h00);
        for (int a = 4; a < 8; a += 2) begin
            r = xorshift();
            wr(a[3:0], r[7:0]);
            wr(a[3:0] + 4'h1, r[15:8]);
            rde(a[3:0], r[7:0]);
            rde(a[3:0] + 4'h1, {6'h00, r[9:8]});
        end
        wr(4'h2, 8'hff);
        wr(4'h3, 8'hff);
        rde(4'h2, 8'h00);
        wr(4'h0, 8'h57);
        rde(4'h0, 8'h50);
        wr(4'h0, 8'h58);
        repeat (20) @(posedge clk_sys);
        rde(4'h2, 8'h00);
        // Count rate for every clock source, timer mode
        cmp(10'h000, 10'h000);
        for (int k = 0; k < 8; k++) begin
            start(8'hc0, {1'b0, k[2:0], 4'h8});
            rd(4'h2, d);
            repeat (126) @(posedge clk_sys);
            rd(4'h2, e);
            check({7'h00, 8'(e - d - rate[k] + 8'h01) <= 8'h02}, 8'h01);
        end
        // Pause holds and resumes; off retains; on clears
        wr(4'h0, 8'h98);
        rd(4'h2, d);
        repeat (5) @(posedge clk_sys);
        rd(4'h2, e);
        check(e, d);
        wr(4'h0, 8'h18);
        rd(4'h2, e);
        check({7'h00, 8'(e - d - 8'h01) < 8'h06}, 8'h01);
        wr(4'h0, 8'h10);
        rd(4'h2, d);
        repeat (5) @(posedge clk_sys);
        rd(4'h2, e);
        check(e, d);
        wr(4'h0, 8'h18);
        rd(4'h2, e);
        check({7'h00, e < 8'h06}, 8'h01);
        cmp(10'h00a, 10'h014);
        for (int f = 0; f < 4; f++) begin
            r = xorshift();
            start({2'b00, f[1:0], r[0], r[1], 2'b00}, 8'h18);
            repeat (4) @(posedge clk_sys);
            @(negedge clk_sys);
            check({7'h00, pin0}, {7'h00, r[0] ^ r[1]});
            repeat (12) @(posedge clk_sys);
            @(negedge clk_sys);
            e = {7'h00, r[1] ^ ((f == 0) ? r[0] : (f == 3) ? !r[0] : f[1])};
            check({7'h00, pin0}, e);
            repeat (8) @(posedge clk_sys);
            @(negedge clk_sys);
            check({7'h00, pin0}, e);
            rde(4'h8, 8'h03);
        end
        cmp(10'h00a, 10'h005);
        start(8'h01, 8'h18);
        repeat (40) @(posedge clk_sys);
        rde(4'h8, 8'h01);
        rd(4'h2, d);
        check({7'h00, d <= 8'h0a}, 8'h01);
        check({6'h00, flagP, flagA}, 8'h01);
        cmp(10'h000, 10'h000);
        start(8'h38, 8'h18);
        repeat (1100) @(posedge clk_sys);
        rd(4'h8, d);
        check({7'h00, d[0]}, 8'h00);
        check({7'h00, pin0}, 8'h01);
        // Capture: edge choice and trigger source
        for (int k = 0; k < 12; k++) begin
            wr(4'h0, 8'h00);
            cmp(10'h000, 10'h000);
            start({2'b01, k[1:0], 2'b00, k[2], 1'b0}, 8'h18);
            repeat (6) begin
                repeat (6) @(posedge clk_sys);
                if (k < 4) extPin <= ~extPin;
            end
            rd(4'h8, d);
            check({7'h00, d[0]}, {7'h00, k[1:0] != 2'b11 && k[3:2] != 2'b10});
        end
        // PWM forced levels, duty and single pulse
        cmp(10'h00a, 10'h014);
        for (int f = 0; f < 4; f++) begin
            r = xorshift();
            start({2'b10, f[1:0], r[0], r[1], 2'b00}, 8'h18);
            n = 0;
            repeat (200) begin
                @(negedge clk_sys);
                n += int'(pin0 === (r[0] ^ r[1]));
            end
            check({7'h00, n >= act[f] - 6 && n <= act[f] + 6}, 8'h01);
            rd(4'h0, d);
            check({7'h00, d[3]}, {7'h00, f != 3});
        end
        print_verdict();
    end
endmodule : periodic_timer_compare_unit_tb
bind periodic_timer_compare_unit periodic_timer_compare_unit_asserts u_chk (
    .clk_sys, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .timerOutputPin0, .timerOutputPin1, .timerOutputEnable, .compareAFlag, .comparePFlag);
`default_nettype wire
